// ===== rtl/vol_pkg.sv
// Shared constants and types for the serial volume level link.
// Summary of operation
// - Update is address byte then data byte.
// - Byte with MSB one is address.
// - Byte with MSB zero is data.
// - Global level takes seven low data bits.
// - Channel gain takes five low data bits.
// - Global code 7f none, 00 most attenuation.
// - Channel code 00 most gain, 1f none.
// - Bytes travel most significant bit first.
// - Data sampled on falling serial clock edge.
// - Shifting only while select is low.
// - Holding registers load on load strobe rise.
// - Host lowers select and load, shifts, raises.
// - Select and load may share one line.
// - Serial clock kept at or below 1 MHz.
// - Six channel gains plus one global level.
// - Global mute asserted from power up.
// - Select high keeps all settings unchanged; here a load strobe rise with select high still commits.
package vol_pkg;
   // ----------------------------------------
   // Widths and counts
   // ----------------------------------------
   localparam int BYTE_W = 8;
   localparam int GLOBAL_W = 7;
   localparam int GAIN_W = 5;
   localparam int NUM_CH = 6;
   localparam int FRAME_W = 2 * BYTE_W;
   localparam int MSB_POS = BYTE_W - 1;
   // ----------------------------------------
   // Address encoding and reset values
   // ----------------------------------------
   localparam logic [6:0] ADDR_GLOBAL = 7'h00;
   localparam logic [6:0] ADDR_CH_FIRST = 7'h01;
   localparam logic [GLOBAL_W-1:0] GLOBAL_RESET = 7'h00;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h1f;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int HCLK_HZ = 40_000_000;
   localparam int SCLK_MAX_HZ = 1_000_000;
   localparam int HALF_CYC = (HCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam logic [4:0] HALF_LOAD = 5'(HALF_CYC - 1);
   // ----------------------------------------
   // Host command registers
   // ----------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_REFUSED = 1;
   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_TAIL, ST_GAP} host_state_t;
endpackage : vol_pkg

// ===== rtl/vol_link_if.sv
// Serial volume link between host and device.
`timescale 1ns/10ps
`default_nettype none
interface vol_link_if;
   logic sclk;
   logic sdata;
   logic select_n;
   logic load_strobe_n;
   modport host (output sclk, output sdata, output select_n, output load_strobe_n);
   modport device (input sclk, input sdata, input select_n, input load_strobe_n);
endinterface : vol_link_if
`default_nettype wire

// ===== rtl/vol_host.sv
// Host end: AHB-Lite command registers driving the serial volume link.
`timescale 1ns/10ps
`default_nettype none
module vol_host (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial link
   vol_link_if.host link
);
   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic refused_reg;
   logic [6:0] cmd_addr_reg;
   logic [6:0] cmd_code_reg;
   logic [vol_pkg::FRAME_W-1:0] frame_reg;
   logic [3:0] bit_reg;
   logic [4:0] timer_reg;
   logic sclk_reg;
   logic sdata_reg;
   logic select_reg;
   vol_pkg::host_state_t state_reg;
   wire busy = (state_reg != vol_pkg::ST_IDLE);
   wire addr_ph = hsel & htrans[1] & hready;
   wire wr_cmd = wr_pend_reg & (wr_addr_reg == vol_pkg::REG_CMD);
   wire start = wr_cmd & ~busy;
   wire timer_done = (timer_reg == 5'h00);
   wire last_bit = (bit_reg == 4'(vol_pkg::FRAME_W - 1));
   wire [31:0] stat_word = {30'h0, refused_reg, busy};
   wire [31:0] cmd_word = {17'h0, cmd_addr_reg, 1'b0, cmd_code_reg};
   wire [31:0] rd_word = (haddr[7:0] == vol_pkg::REG_STAT) ? stat_word :
                         (haddr[7:0] == vol_pkg::REG_CMD) ? cmd_word : 32'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0;
      end else begin
         wr_pend_reg <= addr_ph & hwrite;
         wr_addr_reg <= haddr[7:0];
         hrdata_reg <= (addr_ph & ~hwrite) ? rd_word : hrdata_reg;
      end
   end

   // A command written while a frame is in flight is dropped, not queued.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refused_reg <= 1'b0;
         cmd_addr_reg <= 7'h00;
         cmd_code_reg <= 7'h00;
      end else if (start) begin
         refused_reg <= 1'b0;
         cmd_addr_reg <= hwdata[vol_pkg::CMD_ADDR_LSB +: 7];
         cmd_code_reg <= hwdata[vol_pkg::CMD_CODE_LSB +: 7];
      end else if (wr_cmd) begin
         refused_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= vol_pkg::ST_IDLE;
         timer_reg <= 5'h00;
         bit_reg <= 4'h0;
         frame_reg <= '0;
         sclk_reg <= 1'b1;
         sdata_reg <= 1'b0;
         select_reg <= 1'b1;
      end else begin
         timer_reg <= timer_done ? vol_pkg::HALF_LOAD : timer_reg - 5'h01;
         case (state_reg)
            vol_pkg::ST_IDLE: begin
               timer_reg <= vol_pkg::HALF_LOAD;
               if (start) begin
                  frame_reg <= {1'b1, hwdata[vol_pkg::CMD_ADDR_LSB +: 7],
                                1'b0, hwdata[vol_pkg::CMD_CODE_LSB +: 7]};
                  bit_reg <= 4'h0;
                  select_reg <= 1'b0;
                  state_reg <= vol_pkg::ST_LEAD;
               end
            end
            vol_pkg::ST_LEAD: begin
               if (timer_done) begin
                  sdata_reg <= frame_reg[vol_pkg::FRAME_W-1];
                  state_reg <= vol_pkg::ST_HIGH;
               end
            end
            vol_pkg::ST_HIGH: begin
               if (timer_done) begin
                  sclk_reg <= 1'b0;
                  state_reg <= vol_pkg::ST_LOW;
               end
            end
            vol_pkg::ST_LOW: begin
               if (timer_done) begin
                  sclk_reg <= 1'b1;
                  frame_reg <= {frame_reg[vol_pkg::FRAME_W-2:0], 1'b0};
                  sdata_reg <= frame_reg[vol_pkg::FRAME_W-2];
                  bit_reg <= bit_reg + 4'h1;
                  state_reg <= last_bit ? vol_pkg::ST_TAIL : vol_pkg::ST_HIGH;
               end
            end
            vol_pkg::ST_TAIL: begin
               if (timer_done) begin
                  select_reg <= 1'b1;
                  state_reg <= vol_pkg::ST_GAP;
               end
            end
            vol_pkg::ST_GAP: begin
               if (timer_done) begin
                  state_reg <= vol_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= vol_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign link.sclk = sclk_reg;
   assign link.sdata = sdata_reg;
   // Select and load share one flop, the three-wire arrangement.
   assign link.select_n = select_reg;
   assign link.load_strobe_n = select_reg;
endmodule : vol_host
`default_nettype wire

// ===== rtl/vol_device.sv
// Device end: serial receiver and level holding registers.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module vol_device (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Serial link
   vol_link_if.device link,
   // Level outputs
   output logic [vol_pkg::GLOBAL_W-1:0] global_level,
   output logic [vol_pkg::NUM_CH-1:0][vol_pkg::GAIN_W-1:0] chan_gain,
   output logic global_mute
);

   // ----------------------------------------
   // Address decoding
   // ----------------------------------------
   // Returns a one-hot target: bit 0 global, bits 1..6 channels.
   function automatic logic [vol_pkg::NUM_CH:0] target_of(input logic [6:0] a);
      logic [vol_pkg::NUM_CH:0] t;
      t = '0;
      for (int i = 0; i <= vol_pkg::NUM_CH; i++) begin
         if (a == 7'(vol_pkg::ADDR_GLOBAL + 7'(i))) begin
            t[i] = 1'b1;
         end
      end
      return t;
   endfunction : target_of

   // ----------------------------------------
   // Serial clock domain
   // ----------------------------------------
   logic [2:0] bit_cnt_reg;
   logic [vol_pkg::BYTE_W-2:0] shift_reg;
   logic [vol_pkg::BYTE_W-1:0] byte_reg;
   logic byte_tog_reg;
   wire byte_end = (bit_cnt_reg == 3'(vol_pkg::BYTE_W - 1));

   // Select high holds the bit counter clear, so every frame starts aligned.
   always_ff @(negedge link.sclk or posedge link.select_n) begin
      if (link.select_n) begin
         bit_cnt_reg <= 3'h0;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   always_ff @(negedge link.sclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_reg <= '0;
         byte_reg <= '0;
         byte_tog_reg <= 1'b0;
      end else if (!link.select_n) begin
         shift_reg <= {shift_reg[vol_pkg::BYTE_W-3:0], link.sdata};
         if (byte_end) begin
            byte_reg <= {shift_reg, link.sdata};
            byte_tog_reg <= ~byte_tog_reg;
         end
      end
   end

   // ----------------------------------------
   // Crossing into the system clock domain
   // ----------------------------------------
   // The byte word stays still for eight serial clocks after its toggle,
   // far longer than the toggle takes to cross, so it is read unsynchronised.
   logic [1:0] sel_sync_reg;
   logic [1:0] ld_sync_reg;
   logic [1:0] tog_sync_reg;
   logic sel_d_reg;
   logic ld_d_reg;
   logic tog_d_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_sync_reg <= 2'b11;
         ld_sync_reg <= 2'b11;
         tog_sync_reg <= 2'b00;
         sel_d_reg <= 1'b1;
         ld_d_reg <= 1'b1;
         tog_d_reg <= 1'b0;
      end else begin
         sel_sync_reg <= {sel_sync_reg[0], link.select_n};
         ld_sync_reg <= {ld_sync_reg[0], link.load_strobe_n};
         tog_sync_reg <= {tog_sync_reg[0], byte_tog_reg};
         sel_d_reg <= sel_sync_reg[1];
         ld_d_reg <= ld_sync_reg[1];
         tog_d_reg <= tog_sync_reg[1];
      end
   end

   wire byte_seen = tog_sync_reg[1] ^ tog_d_reg;
   wire sel_fall = sel_d_reg & ~sel_sync_reg[1];
   wire ld_rise = ~ld_d_reg & ld_sync_reg[1];

   // ----------------------------------------
   // Byte capture
   // ----------------------------------------
   // The byte word is copied once, while it is known to be still.
   // Address decoding then works on this local copy, but the data bits are
   // staged straight from the byte word that the serial side writes.
   logic [vol_pkg::BYTE_W-1:0] rx_byte_reg;
   logic rx_new_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_byte_reg <= '0;
         rx_new_reg <= 1'b0;
      end else begin
         rx_new_reg <= byte_seen;
         if (byte_seen) begin
            rx_byte_reg <= byte_reg;
         end
      end
   end

   wire is_addr = rx_byte_reg[vol_pkg::MSB_POS];
   wire [vol_pkg::NUM_CH:0] byte_target = target_of(rx_byte_reg[vol_pkg::BYTE_W-2:0]);

   // ----------------------------------------
   // Byte sequencing
   // ----------------------------------------
   logic [vol_pkg::NUM_CH:0] target_reg;
   logic addr_ok_reg;
   logic data_ok_reg;
   logic [vol_pkg::BYTE_W-2:0] staged_reg;
   logic ld_wait_reg;

   // A load edge that meets a byte still being sorted waits one cycle.
   // Without the wait a fast four-wire host could commit the previous code
   // instead of the data byte that closed its frame.
   wire load_due = ld_rise | ld_wait_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target_reg <= '0;
         addr_ok_reg <= 1'b0;
         data_ok_reg <= 1'b0;
         staged_reg <= '0;
      end else if (sel_fall) begin
         addr_ok_reg <= 1'b0;
         data_ok_reg <= 1'b0;
      end else if (rx_new_reg) begin
         if (is_addr) begin
            target_reg <= byte_target;
            addr_ok_reg <= |byte_target;
            data_ok_reg <= 1'b0;
         end else if (addr_ok_reg) begin
            staged_reg <= byte_reg[vol_pkg::BYTE_W-2:0];
            data_ok_reg <= 1'b1;
         end
      end else if (load_due) begin
         data_ok_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ld_wait_reg <= 1'b0;
      end else begin
         ld_wait_reg <= load_due & rx_new_reg;
      end
   end

   // ----------------------------------------
   // Holding registers
   // ----------------------------------------
   // Codes pass through unchanged: the level converters read them inverted,
   // all ones being the quietest channel and the loudest global setting.
   // A commit needs a load edge, a complete address and data pair,
   // and no byte still waiting to be sorted.
   wire commit = load_due & ~rx_new_reg & data_ok_reg;
   logic [vol_pkg::GLOBAL_W-1:0] global_reg;
   logic mute_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_reg <= vol_pkg::GLOBAL_RESET;
         mute_reg <= 1'b1;
      end else if (commit & target_reg[0]) begin
         global_reg <= staged_reg[vol_pkg::GLOBAL_W-1:0];
         mute_reg <= 1'b0;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < vol_pkg::NUM_CH; ch++) begin : g_chan
         logic [vol_pkg::GAIN_W-1:0] gain_reg;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               gain_reg <= vol_pkg::GAIN_RESET;
            end else if (commit & target_reg[ch+1]) begin
               gain_reg <= staged_reg[vol_pkg::GAIN_W-1:0];
            end
         end
         assign chan_gain[ch] = gain_reg;
      end
   endgenerate

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign global_level = global_reg;
   assign global_mute = mute_reg;
endmodule : vol_device
`default_nettype wire

// ===== testbench/vol_link_chk.sv
// Assertion checker for the serial volume link between host and device.
`timescale 1ns/10ps
`default_nettype none
module vol_link_chk (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Serial link
   input wire logic sclk,
   input wire logic sdata,
   input wire logic select_n,
   input wire logic load_strobe_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   // The hold counter saturates, so a long idle spell never wraps into a false short level.
   logic sclk_reg;
   logic [7:0] held_reg;
   logic [7:0] held_next;
   logic [4:0] falls_reg;
   logic [4:0] falls_next;
   assign held_next = (sclk != sclk_reg) ? 8'h00 : held_reg + {7'h00, held_reg != 8'hff};
   assign falls_next = select_n ? 5'h00 : falls_reg + {4'h0, sclk_reg & ~sclk};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_reg <= 1'b1;
         held_reg <= 8'hff;
         falls_reg <= 5'h00;
      end else begin
         sclk_reg <= sclk;
         held_reg <= held_next;
         falls_reg <= falls_next;
      end
   end
   // ----------------------------------------
   // Link timing and framing
   // ----------------------------------------
   idle_clock_a: assert property (select_n |-> sclk)
      else $error("serial clock low while deselected");
   tied_lines_a: assert property (select_n == load_strobe_n)
      else $error("select and load differ");
   half_period_a: assert property ((sclk != sclk_reg) |-> held_reg >= 8'h13)
      else $error("serial clock level too short");
   data_stable_a: assert property (!sclk && !sclk_reg |-> $stable(sdata))
      else $error("data moved while clock low");
   frame_bits_a: assert property ($rose(select_n) |-> falls_reg == 5'h10)
      else $error("frame does not hold sixteen bits");
   addr_first_a: assert property ($fell(sclk) && falls_reg == 5'h00 |-> sdata)
      else $error("first byte lacks address mark");
   data_first_a: assert property ($fell(sclk) && falls_reg == 5'h08 |-> !sdata)
      else $error("second byte lacks data mark");
   lead_time_a: assert property ($fell(select_n) |-> sclk [*8])
      else $error("clock fell too soon after select");
   late_commit_a: assert property ($rose(load_strobe_n) |-> sclk && held_reg >= 8'h13)
      else $error("load rose too soon after last clock");
   frame_gap_a: assert property ($rose(select_n) |=> select_n [*8])
      else $error("frames too close together");
endmodule : vol_link_chk
`default_nettype wire

// ===== testbench/serial_volume_level_control_tb.sv
// Testbench: host and device joined back to back, plus a device driven by a fault driver.
`timescale 1ns/10ps
`default_nettype none
module serial_volume_level_control_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [vol_pkg::GLOBAL_W-1:0] lvl_a, lvl_b;
   wire logic [vol_pkg::NUM_CH-1:0][vol_pkg::GAIN_W-1:0] gain_a, gain_b;
   wire logic mute_a, mute_b;
   int errors = 0;
   int num_checks = 0;
   vol_link_if link_a ();
   vol_link_if link_b ();
   always #12.5 hclk = ~hclk;
   vol_host vol_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_a.host));
   vol_device vol_device_i (.hclk(hclk), .hresetn(hresetn), .link(link_a.device),
      .global_level(lvl_a), .chan_gain(gain_a), .global_mute(mute_a));
   vol_device vol_device_i2 (.hclk(hclk), .hresetn(hresetn), .link(link_b.device),
      .global_level(lvl_b), .chan_gain(gain_b), .global_mute(mute_b));
   vol_link_chk vol_link_chk_i (.hclk(hclk), .hresetn(hresetn), .sclk(link_a.sclk),
      .sdata(link_a.sdata), .select_n(link_a.select_n), .load_strobe_n(link_a.load_strobe_n));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   // One single AHB-Lite word transfer; read data is taken at the closing edge.
   task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      check("response", 32'h0, {31'h0, hresp});
      if (n >= 100) begin
         errors++;
         end_of_test();
      end
   endtask : bus_cycle
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(posedge hclk);
      do begin
         bus_cycle(vol_pkg::REG_STAT, 1'b0, 32'h0);
         n++;
      end while (rd[vol_pkg::STAT_BUSY] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         errors++;
         end_of_test();
      end
   endtask : wait_idle
   task automatic send(input logic [6:0] a, input logic [6:0] c);
      wait_idle();
      bus_cycle(vol_pkg::REG_CMD, 1'b1, {17'h0, a, 1'b0, c});
      wait_idle();
   endtask : send
   // Fault driver clock runs at 80 ns, off the bus clock phase, and is also run once with select high.
   task automatic shift_b(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         link_b.sdata = v[i];
         #40;
         link_b.sclk = 1'b0;
         #40;
         link_b.sclk = 1'b1;
      end
   endtask : shift_b
   task automatic frame_b(input logic [15:0] v, input int n);
      #7;
      link_b.select_n = 1'b0;
      link_b.load_strobe_n = 1'b0;
      #40;
      shift_b(v, n);
      #40;
      link_b.select_n = 1'b1;
      link_b.load_strobe_n = 1'b1;
      link_b.sdata = ~link_b.sdata;
      #400;
   endtask : frame_b
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic reset_values();
      check("global level", 32'(vol_pkg::GLOBAL_RESET), 32'(lvl_a));
      check("mute", 32'h1, {31'h0, mute_a});
      for (int i = 0; i < vol_pkg::NUM_CH; i++) begin
         check("gain", 32'h1f, 32'(gain_a[i]));
      end
   endtask : reset_values
   task automatic global_codes();
      logic [6:0] codes [3] = '{7'h7f, 7'h00, 7'h2a};
      foreach (codes[k]) begin
         send(vol_pkg::ADDR_GLOBAL, codes[k]);
         check("global level", 32'(codes[k]), 32'(lvl_a));
         check("mute", 32'h0, {31'h0, mute_a});
         check("gain", 32'h1f, 32'(gain_a[0]));
      end
   endtask : global_codes
   task automatic channel_codes();
      logic [4:0] g [6] = '{5'h00, 5'h10, 5'h1f, 5'h0f, 5'h15, 5'h03};
      for (int i = 0; i < 6; i++) begin
         send(vol_pkg::ADDR_CH_FIRST + 7'(i), {2'b11, g[i]});
      end
      for (int i = 0; i < 6; i++) begin
         check("gain", 32'(g[i]), 32'(gain_a[i]));
      end
      send(7'h07, 7'h11);
      send(7'h7f, 7'h11);
      check("global level", 32'h2a, 32'(lvl_a));
      check("gain", 32'h00, 32'(gain_a[0]));
      bus_cycle(vol_pkg::REG_CMD, 1'b0, 32'h0);
      check("command", 32'h7f11, rd);
   endtask : channel_codes
   task automatic busy_and_unmapped();
      wait_idle();
      bus_cycle(vol_pkg::REG_CMD, 1'b1, 32'h0107);
      bus_cycle(vol_pkg::REG_CMD, 1'b1, 32'h0208);
      wait_idle();
      check("refused", 32'h1, {31'h0, rd[vol_pkg::STAT_REFUSED]});
      check("gain", 32'h07, 32'(gain_a[0]));
      check("gain", 32'h10, 32'(gain_a[1]));
      bus_cycle(8'h08, 1'b1, 32'h017f);
      bus_cycle(8'h08, 1'b0, 32'h0);
      check("unmapped", 32'h0, rd);
      check("select", 32'h1, {31'h0, link_a.select_n});
   endtask : busy_and_unmapped
   task automatic fault_link();
      frame_b(16'h807f, 16);
      check("far level", 32'h7f, 32'(lvl_b));
      check("far mute", 32'h0, {31'h0, mute_b});
      frame_b(16'h0005, 8);
      check("far level", 32'h7f, 32'(lvl_b));
      shift_b(16'h8105, 16);
      #400;
      check("far gain", 32'h1f, 32'(gain_b[0]));
      link_b.select_n = 1'b0;
      link_b.load_strobe_n = 1'b0;
      #40;
      shift_b(16'h8103, 16);
      #40;
      link_b.select_n = 1'b1;
      #400;
      check("far gain", 32'h1f, 32'(gain_b[0]));
      link_b.load_strobe_n = 1'b1;
      #400;
      check("far gain", 32'h03, 32'(gain_b[0]));
   endtask : fault_link
   initial begin
      link_b.sclk = 1'b1;
      link_b.sdata = 1'b0;
      link_b.select_n = 1'b1;
      link_b.load_strobe_n = 1'b1;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      reset_values();
      global_codes();
      channel_codes();
      busy_and_unmapped();
      fault_link();
      end_of_test();
   end
endmodule : serial_volume_level_control_tb
`default_nettype wire
